// ### hdl/cmzc_map.vh
// Register offsets, field positions, reset values and timing counts
`ifndef CMZC_MAP_VH
`define CMZC_MAP_VH

// Register byte offsets
`define CMZC_CTRL_ADDR      8'h00
`define CMZC_ZERO_ADDR      8'h04
`define CMZC_SPEED_ADDR     8'h08
`define CMZC_STAT_ADDR      8'h0C
`define CMZC_ATT_BASE       8'h10

// Control fields
`define CMZC_SOFT_MUTE_BIT      0
`define CMZC_SOFT_RESET_N_BIT       1
`define CMZC_ADCPW_BIT      2
`define CMZC_DACPW_BIT      3
`define CMZC_CTRL_RST       8'h0E

// Zero detect fields
`define CMZC_OVERFLOW_FLAG_ENABLE_BIT       7
`define CMZC_ZSEL_LSB       3
`define CMZC_ZERO_RST       8'h38

// Ramp speed reset
`define CMZC_SPEED_RST      2'b00

// Attenuation codes
`define CMZC_ATT_MUTE       8'h7F
`define CMZC_ATT_ZERO       8'h00

// Frame-period counts
`define CMZC_ADC_GD         16
`define CMZC_ADC_INIT       522
`define CMZC_ZERO_FRAMES    8192
`define CMZC_GAIN_FULL      1792
`define CMZC_STEP_SLOW      14
`define CMZC_STEP_MID       7
`define CMZC_STEP_FAST      2

`endif

// ### hdl/cmzc_ramp.v
// Soft-ramp attenuator for one channel, one step of 1, 2 or 7 gain levels per frame
`timescale 1ns/1ps
`default_nettype none
`include "cmzc_map.vh"

module cmzc_ramp
(
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        aclken,
    // Control
    input  wire        frame_tick,
    input  wire        hold_zero,
    input  wire [7:0]  target,
    input  wire [1:0]  ramp_speed_select,
    // Status
    output reg  [10:0] gain_level_q
);

    // Levels moved per frame, scaled so 7FH equals 1792 levels
    wire [10:0] step;
    wire [10:0] goal;
    assign step = (ramp_speed_select == 2'b00) ? 11'd1 :
                  (ramp_speed_select == 2'b01) ? 11'd2 : 11'd7;
    assign goal = (target >= `CMZC_ATT_MUTE) ? 11'd1792 :
                  (target[6:0] * 11'd14);

    // Ramp toward goal from wherever the level now is
    always @(posedge aclk)
    begin
        if (!aresetn)
            gain_level_q <= 11'd0;
        else if (aclken)
        begin
            if (hold_zero)
                gain_level_q <= 11'd0;
            else if (frame_tick)
            begin
                if (gain_level_q + step <= goal)
                    gain_level_q <= gain_level_q + step;
                else if (gain_level_q > goal + step)
                    gain_level_q <= gain_level_q - step;
                else
                    gain_level_q <= goal;
            end
        end
    end

endmodule
`default_nettype wire

// ### hdl/cmzc_ctrl.v
// Codec level, mute, zero and overflow flag control with AXI4-Lite slave
// Behaviour
// - Overflow detection only with enable in serial mode
// - Overflow flag when left or right overflows
// - Overflow flag delayed sixteen frames
// - Overflow flag low 522 frames after power-up
// - Group select used in serial, force-all low
// - Enable in serial mode puts overflow on flag two
// - Force-all gives mode 0; parallel gives 7
// - Modes 1-5 split channels; 0 all on one, 6 all on two; others both low
// - Flag after 8192 zero frames, drop at once
// - Attenuation 00H..7EH steps, 7FH up mutes
// - Ramp time 1792, 896 or 256 frames
// - Mode 0 steps 1792 levels, one per frame
// - Power-down clears levels; soft reset holds zero
// - Soft reset release ramps to programmed value
// - Soft mute ramps to full mute
// - Mute release ramps back to programmed level
// - Early mute release reverses from reached point
// - Start only with frame clock present, on edge
// - Power-down resets registers, flags low
// - ADC output valid 522 frames after power-up
// - Separate ADC and DAC power bits
// - ADC off holds output low; DAC off flags high
`timescale 1ns/1ps
`default_nettype none
`include "cmzc_map.vh"

module cmzc_ctrl
#(
    parameter ZERO_FRAMES = `CMZC_ZERO_FRAMES
)
(
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        aclken,
    // Device pins
    input  wire        power_down_n,
    input  wire        frame_clock,
    input  wire        serial_mode,
    input  wire        zero_force_all,
    input  wire        overflow_left,
    input  wire        overflow_right,
    input  wire [5:0]  channel_nonzero,
    input  wire        frame_sample,
    input  wire        adc_data_in,
    output reg         adc_serial_out,
    output reg         zero_flag_one,
    output reg         zero_flag_two,
    output reg         adc_valid,
    output wire [65:0] gain_levels,
    // AXI4-Lite write
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    //------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------
    reg [1:0] pdn_sync_q;
    reg [2:0] fck_sync_q;
    reg [1:0] ovl_sync_q;
    reg [1:0] ovr_sync_q;
    reg [1:0] ser_sync_q;
    reg [1:0] zfa_sync_q;

    // Two flops on power-down, frame clock, overflow, serial and force-all pins; frame clock gets a third for edges
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pdn_sync_q <= 2'b00;
            fck_sync_q <= 3'b000;
            ovl_sync_q <= 2'b00;
            ovr_sync_q <= 2'b00;
            ser_sync_q <= 2'b00;
            zfa_sync_q <= 2'b00;
        end
        else if (aclken)
        begin
            pdn_sync_q <= {pdn_sync_q[0], power_down_n};
            fck_sync_q <= {fck_sync_q[1:0], frame_clock};
            ovl_sync_q <= {ovl_sync_q[0], overflow_left};
            ovr_sync_q <= {ovr_sync_q[0], overflow_right};
            ser_sync_q <= {ser_sync_q[0], serial_mode};
            zfa_sync_q <= {zfa_sync_q[0], zero_force_all};
        end
    end

    wire pdn_n    = pdn_sync_q[1];
    wire serial   = ser_sync_q[1];
    wire force_all = zfa_sync_q[1];
    // Frame tick on a rising frame clock edge
    wire frame_tick = fck_sync_q[1] & ~fck_sync_q[2];

    //------------------------------------------------------------
    // Power state
    //------------------------------------------------------------
    reg        running_q;
    reg [9:0]  init_cnt_q;
    wire       in_pd = ~pdn_n;

    // Leave power-down only at the first frame edge after release
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            running_q  <= 1'b0;
            init_cnt_q <= 10'd0;
        end
        else if (aclken)
        begin
            if (in_pd)
            begin
                running_q  <= 1'b0;
                init_cnt_q <= 10'd0;
            end
            else if (frame_tick)
            begin
                running_q <= 1'b1;
                if (running_q && init_cnt_q != `CMZC_ADC_INIT)
                    init_cnt_q <= init_cnt_q + 10'd1;
            end
        end
    end

    wire init_done = running_q && (init_cnt_q == `CMZC_ADC_INIT);

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    reg [7:0] ctrl_q;
    reg [7:0] zero_q;
    reg [1:0] speed_q;
    reg [7:0] att_q [0:5];
    integer   i;

    wire soft_mute   = ctrl_q[`CMZC_SOFT_MUTE_BIT];
    wire soft_reset_n    = ctrl_q[`CMZC_SOFT_RESET_N_BIT];
    wire adc_pw  = ctrl_q[`CMZC_ADCPW_BIT];
    wire dac_pw  = ctrl_q[`CMZC_DACPW_BIT];
    wire overflow_flag_enable    = zero_q[`CMZC_OVERFLOW_FLAG_ENABLE_BIT];
    wire [3:0] zsel = zero_q[`CMZC_ZSEL_LSB+3:`CMZC_ZSEL_LSB];

    // AXI write: take address and data together when both are offered
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;

    // Decode an attenuation slot, 6 means none
    function [2:0] att_index;
        input [7:0] addr;
        reg   [7:0] off;
        begin
            off = addr - `CMZC_ATT_BASE;
            if (addr >= `CMZC_ATT_BASE && off < 8'd24 && addr[1:0] == 2'b00)
                att_index = off[4:2];
            else
                att_index = 3'd6;
        end
    endfunction

    wire [2:0] wr_idx = att_index(s_axi_awaddr);
    wire       wr_ok  = (s_axi_awaddr == `CMZC_CTRL_ADDR) ||
                        (s_axi_awaddr == `CMZC_ZERO_ADDR) ||
                        (s_axi_awaddr == `CMZC_SPEED_ADDR) ||
                        (wr_idx != 3'd6);

    // Register writes; power-down restores defaults and blocks writes
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q  <= `CMZC_CTRL_RST;
            zero_q  <= `CMZC_ZERO_RST;
            speed_q <= `CMZC_SPEED_RST;
            for (i = 0; i < 6; i = i + 1)
                att_q[i] <= `CMZC_ATT_ZERO;
        end
        else if (aclken)
        begin
            if (in_pd)
            begin
                ctrl_q  <= `CMZC_CTRL_RST;
                zero_q  <= `CMZC_ZERO_RST;
                speed_q <= `CMZC_SPEED_RST;
                for (i = 0; i < 6; i = i + 1)
                    att_q[i] <= `CMZC_ATT_ZERO;
            end
            else if (wr_go && s_axi_wstrb[0])
            begin
                if (s_axi_awaddr == `CMZC_CTRL_ADDR)
                    ctrl_q <= s_axi_wdata[7:0];
                else if (s_axi_awaddr == `CMZC_ZERO_ADDR)
                    zero_q <= s_axi_wdata[7:0];
                else if (s_axi_awaddr == `CMZC_SPEED_ADDR)
                    speed_q <= s_axi_wdata[1:0];
                else if (wr_idx != 3'd6)
                    att_q[wr_idx] <= s_axi_wdata[7:0];
            end
        end
    end

    // Write response one cycle after acceptance
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end
        else if (aclken)
        begin
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Channel ramps
    //------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : ch
            // Mute drives the target to 7FH; release reverses in place
            wire [7:0] tgt = soft_mute ? `CMZC_ATT_MUTE : att_q[g];
            cmzc_ramp u_ramp
            (
                .aclk              (aclk),
                .aresetn           (aresetn),
                .aclken            (aclken),
                .frame_tick        (frame_tick & running_q),
                .hold_zero         (in_pd | ~soft_reset_n),
                .target            (tgt),
                .ramp_speed_select (speed_q),
                .gain_level_q      (gain_levels[g*11 +: 11])
            );
        end
    endgenerate

    //------------------------------------------------------------
    // Overflow path
    //------------------------------------------------------------
    reg [15:0] ovf_pipe_q;
    wire       ovf_raw = ovl_sync_q[1] | ovr_sync_q[1];
    wire       ovf_on  = serial & overflow_flag_enable & init_done;
    wire       overflow_flag = ovf_on & ovf_pipe_q[15];

    // Sixteen-frame delay matching the ADC path
    always @(posedge aclk)
    begin
        if (!aresetn)
            ovf_pipe_q <= 16'h0000;
        else if (aclken)
        begin
            if (!init_done)
                ovf_pipe_q <= 16'h0000;
            else if (frame_tick)
                ovf_pipe_q <= {ovf_pipe_q[14:0], ovf_raw};
        end
    end

    //------------------------------------------------------------
    // Zero detection
    //------------------------------------------------------------
    reg [13:0] zcnt_q [0:5];
    reg [5:0]  zlong;

    // Per-channel count of consecutive zero frames
    always @(posedge aclk)
    begin
        if (!aresetn)
            for (i = 0; i < 6; i = i + 1)
                zcnt_q[i] <= 14'd0;
        else if (aclken)
            for (i = 0; i < 6; i = i + 1)
                if (!running_q || channel_nonzero[i])
                    zcnt_q[i] <= 14'd0;
                else if (frame_sample && zcnt_q[i] != ZERO_FRAMES[13:0])
                    zcnt_q[i] <= zcnt_q[i] + 14'd1;
    end

    // Channel is long-zero only while current sample is zero too
    always @*
    begin
        for (i = 0; i < 6; i = i + 1)
            zlong[i] = (zcnt_q[i] == ZERO_FRAMES[13:0]) & ~channel_nonzero[i];
    end

    // Effective grouping mode
    wire [3:0] mode = force_all ? 4'd0 :
                      serial    ? zsel : 4'd7;
    // Group one mask: first six-minus-mode channels, L1 at bit 0
    wire [5:0] g1   = (mode < 4'd7) ? (6'h3F >> mode[2:0]) : 6'h00;
    wire [5:0] g2   = (mode < 4'd7) ? (~g1 & 6'h3F) : 6'h00;
    wire       z1   = (g1 != 6'h00) && ((zlong & g1) == g1);
    wire       z2   = (g2 != 6'h00) && ((zlong & g2) == g2);

    // Flag pins with power priorities
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            zero_flag_one <= 1'b0;
            zero_flag_two <= 1'b0;
        end
        else if (aclken)
        begin
            if (in_pd)
            begin
                zero_flag_one <= 1'b0;
                zero_flag_two <= 1'b0;
            end
            else if (!dac_pw || !soft_reset_n)
            begin
                zero_flag_one <= 1'b1;
                zero_flag_two <= 1'b1;
            end
            else
            begin
                zero_flag_one <= z1;
                zero_flag_two <= (serial & overflow_flag_enable) ? overflow_flag : z2;
            end
        end
    end

    //------------------------------------------------------------
    // ADC output gate
    //------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            adc_serial_out <= 1'b0;
            adc_valid      <= 1'b0;
        end
        else if (aclken)
        begin
            adc_valid      <= init_done & adc_pw & soft_reset_n;
            adc_serial_out <= adc_data_in & init_done & adc_pw & soft_reset_n;
        end
    end

    //------------------------------------------------------------
    // AXI read
    //------------------------------------------------------------
    wire [2:0] rd_idx = att_index(s_axi_araddr);
    assign s_axi_arready = ~s_axi_rvalid;

    // Read data: registers plus a status word of live state
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end
        else if (aclken)
        begin
            if (s_axi_arvalid && !s_axi_rvalid)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                if (s_axi_araddr == `CMZC_CTRL_ADDR)
                    s_axi_rdata <= {24'h00_0000, ctrl_q};
                else if (s_axi_araddr == `CMZC_ZERO_ADDR)
                    s_axi_rdata <= {24'h00_0000, zero_q};
                else if (s_axi_araddr == `CMZC_SPEED_ADDR)
                    s_axi_rdata <= {30'h0000_0000, speed_q};
                else if (s_axi_araddr == `CMZC_STAT_ADDR)
                    s_axi_rdata <= {27'h000_0000, overflow_flag,
                                    zero_flag_two, zero_flag_one,
                                    init_done, running_q};
                else if (rd_idx != 3'd6)
                    s_axi_rdata <= {24'h00_0000, att_q[rd_idx]};
                else
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### tb/cmzc_ctrl_sva.sv
// Assertion checker for the codec level, mute and flag control
`timescale 1ns/1ps
`default_nettype none
`include "cmzc_map.vh"
module cmzc_ctrl_sva
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Device pins
    input wire logic        power_down_n,
    input wire logic [5:0]  channel_nonzero,
    input wire logic        adc_data_in,
    input wire logic        adc_serial_out,
    input wire logic        adc_valid,
    input wire logic        zero_flag_one,
    input wire logic        zero_flag_two,
    input wire logic [65:0] gain_levels,
    // Register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_bvalid
);
    logic       flags_up_q;
    logic       rst_off_q;
    logic [5:0] up_cnt_q;
    wire        ctrl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                          && s_axi_awaddr == `CMZC_CTRL_ADDR;
    wire        up = up_cnt_q == 6'h3F;
    wire [10:0] ga = gain_levels[10:0];
    wire [10:0] gb = gain_levels[21:11];

    // Mirror of the control bits that force flags and hold the gain
    always @(posedge aclk)
    begin
        if (!aresetn || !power_down_n)
        begin
            flags_up_q <= 1'b0;
            rst_off_q  <= 1'b0;
            up_cnt_q   <= 6'h00;
        end
        else
        begin
            if (ctrl_wr)
            begin
                flags_up_q <= !(s_axi_wdata[3] && s_axi_wdata[1]);
                rst_off_q  <= !s_axi_wdata[1];
            end
            if (!up)
                up_cnt_q <= up_cnt_q + 6'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_flag_drop:
        assert property (zero_flag_one && &channel_nonzero && up
            && !flags_up_q |=> !zero_flag_one)
        else $error("flag one stayed high with data present");
    a_forced_hi:
        assert property ((flags_up_q && up) [*3] |->
            zero_flag_one && zero_flag_two)
        else $error("flags not high with converters off");
    a_pin_low:
        assert property ((!power_down_n) [*5] |->
            !zero_flag_one && !zero_flag_two && !adc_valid)
        else $error("flags or adc valid high in power-down");
    a_adc_quiet:
        assert property (!adc_valid && !$past(adc_valid) |-> !adc_serial_out)
        else $error("adc output not low while not valid");
    a_adc_pass:
        assert property (adc_valid && $past(adc_valid) |->
            adc_serial_out == $past(adc_data_in))
        else $error("adc output does not follow input");
    a_gain_hold:
        assert property (rst_off_q [*3] |-> gain_levels == 66'h0)
        else $error("gain not held at zero in soft reset");
    a_gain_step:
        assert property (up && $past(up) && !rst_off_q && !$past(rst_off_q)
            |-> ga <= $past(ga) + 11'd7 && $past(ga) <= ga + 11'd7)
        else $error("gain moved more than one step");
    a_gain_cap:
        assert property (ga <= 11'd1792 && gb <= 11'd1792)
        else $error("gain beyond full mute");
    a_wr_answer:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
            |=> s_axi_bvalid)
        else $error("write response late");

    c_zero_flag: cover property (zero_flag_one && !flags_up_q && up);
    c_soft_rst: cover property (rst_off_q);
    c_full_mute: cover property (gb == 11'd1792);
endmodule

bind cmzc_ctrl cmzc_ctrl_sva u_sva (.*);
`default_nettype wire

// ### tb/cmzc_dsp.sv
// Behavioural audio sample source on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module cmzc_dsp
#(
    parameter FP = 16
)
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Sample content chosen by the bench
    input  wire logic [5:0] nz_mask,
    // Sample port
    output wire logic       frame_clock,
    output wire logic       frame_sample,
    output wire logic [5:0] channel_nonzero,
    output wire logic       adc_data_in
);
    logic [7:0] cnt_q = 8'h00;

    // Free-running frame counter, frame clock present from the start
    always @(posedge aclk)
    begin
        if (!aresetn || cnt_q == FP - 1)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_q + 8'h01;
    end

    // Frame clock, one sample pulse per frame, changing adc bits
    assign frame_clock     = cnt_q < FP / 2;
    assign frame_sample    = cnt_q == 8'h00;
    assign channel_nonzero = nz_mask;
    assign adc_data_in     = cnt_q[0] ^ cnt_q[2];
endmodule
`default_nettype wire

// ### tb/cmzc_ctrl_tb.sv
// Self-checking bench for the codec level, mute and flag control
`timescale 1ns/1ps
`default_nettype none
`include "cmzc_map.vh"
module cmzc_ctrl_tb;
    localparam int FP = 16;
    localparam int ZF = 8;
    localparam int LIMIT = 70000;
    logic        aclk, aresetn = 1'b0, power_down_n = 1'b0;
    logic        serial_mode = 1'b1, zero_force_all = 1'b0;
    logic        ovf_l = 1'b1, ovf_r = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [5:0]  nz_mask = 6'h00, chan_nz;
    logic [1:0]  bresp, rresp;
    logic [65:0] gain;
    logic        fclk, fsmp, adc_in, adc_out, zf1, zf2, adc_ok;
    logic        awready, wready, arready, bvalid, rvalid;
    int          failures = 0, checks = 0, cyc = 0, m, p, n;

    cmzc_dsp #(.FP(FP)) u_dsp
    (
        .aclk, .aresetn, .nz_mask,
        .frame_clock(fclk), .frame_sample(fsmp),
        .channel_nonzero(chan_nz), .adc_data_in(adc_in)
    );

    cmzc_ctrl #(.ZERO_FRAMES(ZF)) u_dut
    (
        .aclk, .aresetn, .aclken(1'b1), .power_down_n, .frame_clock(fclk),
        .serial_mode, .zero_force_all,
        .overflow_left(ovf_l), .overflow_right(ovf_r),
        .channel_nonzero(chan_nz), .frame_sample(fsmp),
        .adc_data_in(adc_in), .adc_serial_out(adc_out),
        .zero_flag_one(zf1), .zero_flag_two(zf2), .adc_valid(adc_ok),
        .gain_levels(gain), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1)
    );

    // Clock
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // Cycle ceiling against a hang
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            failures = failures + 1;
            close_out;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Wait whole frames, ending between edges
    task automatic frames(input int k);
        repeat (k * FP) @(posedge aclk);
        @(negedge aclk);
    endtask

    function automatic logic [10:0] g(input int c);
        return gain[c * 11 +: 11];
    endfunction

    // Register write; ready and response taken at the edge they stand
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        check(bresp, 0);
    endtask

    // Register read with expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = 2'b00);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        check(rdata, e);
        check(rresp, er);
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        frames(2);
        @(posedge aclk) power_down_n <= 1'b1;
        frames(2);
        rd(`CMZC_CTRL_ADDR, 32'h0E);
        rd(`CMZC_ZERO_ADDR, 32'h38);
        rd(`CMZC_SPEED_ADDR, 32'h0);
        for (m = 0; m < 6; m++)
            rd(`CMZC_ATT_BASE + 8'(4 * m), 32'h0);
        rd(8'h40, 32'h0, 2'b10);
        wr(`CMZC_ZERO_ADDR, 32'hB8);
        $display("T1 done");
        frames(490);
        check(adc_ok, 1'b0);
        check(zf2, 1'b0);
        for (n = 0; n < 40 * FP && adc_ok !== 1'b1; n++) @(negedge aclk);
        check(adc_ok, 1'b1);
        frames(20);
        check(zf2, 1'b1);
        @(posedge aclk) ovf_l <= 1'b0;
        frames(20);
        check(zf2, 1'b0);
        @(posedge aclk) ovf_r <= 1'b1;
        frames(14);
        check(zf2, 1'b0);
        frames(4);
        check(zf2, 1'b1);
        @(posedge aclk) serial_mode <= 1'b0;
        frames(20);
        check(zf2, 1'b0);
        @(posedge aclk) serial_mode <= 1'b1;
        ovf_r <= 1'b0;
        frames(20);
        $display("T2 done");
        wr(`CMZC_CTRL_ADDR, 32'h0A);
        frames(1);
        check({adc_ok, adc_out}, 2'b00);
        rd(`CMZC_ZERO_ADDR, 32'hB8);
        wr(`CMZC_CTRL_ADDR, 32'h06);
        frames(1);
        check({zf1, zf2}, 2'b11);
        wr(`CMZC_CTRL_ADDR, 32'h0E);
        $display("T3 done");
        for (p = 0; p < 2; p++)
            for (m = 0; m < 16; m++)
            begin
                @(posedge aclk) nz_mask <= p ? 6'h20 : 6'h01;
                wr(`CMZC_ZERO_ADDR, 32'(m << 3));
                frames(ZF + 4);
                check(zf1, p && m > 0 && m < 6);
                check(zf2, !p && m > 0 && m < 6);
            end
        @(posedge aclk) nz_mask <= 6'h00;
        zero_force_all <= 1'b1;
        frames(ZF + 6);
        check({zf1, zf2}, 2'b10);
        @(posedge aclk) nz_mask <= 6'h3F;
        frames(1);
        check(zf1, 1'b0);
        @(posedge aclk) serial_mode <= 1'b0;
        zero_force_all <= 1'b0;
        nz_mask <= 6'h00;
        frames(ZF + 6);
        check({zf1, zf2}, 2'b00);
        @(posedge aclk) serial_mode <= 1'b1;
        $display("T4 done");
        wr(`CMZC_SPEED_ADDR, 32'h2);
        wr(`CMZC_ATT_BASE, 32'h7E);
        frames(240);
        check(g(0) < 11'd1764, 1'b1);
        frames(20);
        check(g(0), 11'd1764);
        wr(`CMZC_ATT_BASE, 32'h80);
        frames(8);
        check(g(0), 11'd1792);
        wr(`CMZC_SPEED_ADDR, 32'h0);
        wr(`CMZC_ATT_BASE, 32'h00);
        frames(50);
        check(g(0) inside {[1739:1745]}, 1'b1);
        wr(`CMZC_SPEED_ADDR, 32'h1);
        frames(50);
        check(g(0) inside {[1636:1646]}, 1'b1);
        wr(`CMZC_SPEED_ADDR, 32'h3);
        frames(250);
        check(g(0), 11'd0);
        $display("T5 done");
        wr(`CMZC_CTRL_ADDR, 32'h0F);
        frames(100);
        wr(`CMZC_CTRL_ADDR, 32'h0E);
        frames(90);
        check(g(1) > 11'd0, 1'b1);
        frames(20);
        check(g(1), 11'd0);
        wr(`CMZC_CTRL_ADDR, 32'h0F);
        frames(270);
        check(g(1), 11'd1792);
        wr(`CMZC_CTRL_ADDR, 32'h0E);
        frames(270);
        check(g(1), 11'd0);
        $display("T6 done");
        wr(`CMZC_ATT_BASE, 32'h40);
        frames(140);
        check(g(0), 11'd896);
        wr(`CMZC_CTRL_ADDR, 32'h0C);
        frames(1);
        check(g(0), 11'd0);
        rd(`CMZC_ATT_BASE, 32'h40);
        wr(`CMZC_CTRL_ADDR, 32'h0E);
        frames(20);
        check(g(0) inside {[1:895]}, 1'b1);
        frames(140);
        check(g(0), 11'd896);
        $display("T7 done");
        wr(`CMZC_CTRL_ADDR, 32'h06);
        @(posedge aclk) power_down_n <= 1'b0;
        frames(1);
        check({zf1, zf2, adc_ok}, 3'b000);
        rd(`CMZC_ATT_BASE, 32'h0);
        rd(`CMZC_CTRL_ADDR, 32'h0E);
        $display("T8 done");
        close_out;
    end
endmodule
`default_nettype wire
